/* hdl/ahl_pkg.sv */
package ahl_pkg;

    // --------------------
    // Register map (byte addresses, one aligned word each)
    // --------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00; // Loop, polarity, edges
    localparam logic [7:0] ADDR_SMOOTH  = 8'h04; // Smoothing factors
    localparam logic [7:0] ADDR_CMD     = 8'h08; // Command strobes
    localparam logic [7:0] ADDR_STATUS  = 8'h0C; // Latch, homing state
    localparam logic [7:0] ADDR_LATCH_A = 8'h10; // Axis A capture
    localparam logic [7:0] ADDR_LATCH_B = 8'h14; // Axis B capture
    localparam logic [7:0] ADDR_SPEED   = 8'h18; // Slew low, creep high

    // --------------------
    // Field positions
    // --------------------
    localparam int CTRL_DUAL_BIT    = 0; // dual_loop_enable
    localparam int CTRL_HPOL_BIT    = 1; // Home polarity invert
    localparam int CTRL_EDGE_A_BIT  = 2; // 1 = rising capture, A
    localparam int CTRL_EDGE_B_BIT  = 3; // 1 = rising capture, B
    localparam int CTRL_STEPPER_BIT = 4; // Stepper axis
    localparam int CMD_ARM_A_BIT    = 0; // latch_arm axis A
    localparam int CMD_ARM_B_BIT    = 1; // latch_arm axis B
    localparam int CMD_EDGE_BIT     = 2; // find_switch_edge
    localparam int CMD_INDEX_BIT    = 3; // find_index_routine
    localparam int CMD_HOME_BIT     = 4; // home_sequence
    localparam int CMD_VEC_BIT      = 5; // 1 = vector move type

    // --------------------
    // Reset values and timing
    // --------------------
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] SMOOTH_RST = 32'hFFFF_FFFF; // Both 1.0: no filtering
    localparam logic [31:0] SPEED_RST  = 32'h0010_0100;
    localparam int          CLK_MHZ    = 125;
    localparam int          LATCH_NS   = 1000; // Capture latency bound
    localparam int          LATCH_CYC  = (LATCH_NS * CLK_MHZ) / 1000;

    // --------------------
    // Types
    // --------------------
    typedef enum logic [2:0] {
        HS_IDLE  = 3'b000,
        HS_SLEW  = 3'b001,
        HS_DECEL = 3'b011,
        HS_CREEP = 3'b010,
        HS_INDEX = 3'b110
    } ahl_home_e;

    typedef struct packed {
        logic        home_in;    // Home switch level
        logic        index_in;   // Encoder index pulse
        logic        stopped;    // Profiler reports zero speed
    } ahl_sense_s;

    typedef struct packed {
        logic        active;     // Sequence running
        logic        dir_fwd;    // 1 = forward
        logic        decel;      // Request decelerate to stop
        logic [15:0] speed;      // Commanded speed
        logic        zero_pos;   // One-cycle: set position to zero
    } ahl_move_s;

endpackage : ahl_pkg

/* hdl/ahl_latch.sv */
// Single-axis position latch: arms, captures once on chosen edge, holds result
module ahl_latch #(
    parameter int POS_W = 32            // Position width
) (
    input  wire logic             aclk,      // Clock
    input  wire logic             aresetn,   // Sync reset, active low
    input  wire logic             arm,       // One-cycle arm request
    input  wire logic             rising,    // 1 = capture on rising edge
    input  wire logic             lat_in,    // Latch trigger input
    input  wire logic [POS_W-1:0] pos,       // Live encoder position
    output logic                  armed,     // 1 while armed, not yet triggered
    output logic      [POS_W-1:0] captured   // Held captured position
);
    logic prev_r;   // Last input level for edge detection
    logic hit;      // Selected edge seen this cycle

    // --------------------
    // Edge select
    // --------------------
    assign hit = rising ? (lat_in & ~prev_r) : (~lat_in & prev_r);

    // Input history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= lat_in;
        end
    end

    // Armed flag: capture wins only when already armed, arm wins over nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed <= 1'b0;
        end else if (armed && hit) begin
            armed <= 1'b0;                   // [R17] [R16]
        end else if (arm) begin
            armed <= 1'b1;                   // [R16]
        end
    end

    // Capture register: one cycle after the edge, well under the bound
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            captured <= '0;
        end else if (armed && hit) begin
            captured <= pos;                 // [R13] [R14] [R18] [R20]
        end
    end
endmodule : ahl_latch

/* hdl/ahl_axis_ctrl.sv */
// What this block does
// [R1] Dual loop: P,I load, D motor
// [R2] Enable bit switches split filter
// [R3] Factor 0..1, one means none
// [R4] Independent or vector factor per move
// [R5] Find edge: slew to transition, stop
// [R6] Start direction from home level
// [R7] Polarity setting interprets home input
// [R8] Decelerate on switch change
// [R9] Creep back until switch toggles
// [R10] Forward until index pulse
// [R11] Zero position at index
// [R12] Find index alone; home = edge+index
// [R13] Armed latch captures on chosen edge
// [R14] Capture latency under one microsecond
// [R15] Input one axis A, two B
// [R16] Status one while armed
// [R17] One capture per arming
// [R18] Capture held until next one
// [R19] Secondary encoder off for stepper
// [R20] Unarmed edges ignored
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
module ahl_axis_ctrl #(
    parameter int POS_W = 32 // Encoder position width
) (
    input  wire logic                aclk, // Clock, 125 MHz
    input  wire logic                aresetn, // Sync reset, active low
    // AXI4-Lite slave
    input  wire logic [7:0]          s_axi_awaddr, // Write address
    input  wire logic                s_axi_awvalid, // Address valid
    output logic                     s_axi_awready, // Address ready
    input  wire logic [31:0]         s_axi_wdata, // Write data
    input  wire logic [3:0]          s_axi_wstrb, // Write strobes
    input  wire logic                s_axi_wvalid, // Data valid
    output logic                     s_axi_wready, // Data ready
    output logic [1:0]               s_axi_bresp, // Write response
    output logic                     s_axi_bvalid, // Response valid
    input  wire logic                s_axi_bready, // Response ready
    input  wire logic [7:0]          s_axi_araddr, // Read address
    input  wire logic                s_axi_arvalid, // Address valid
    output logic                     s_axi_arready, // Address ready
    output logic [31:0]              s_axi_rdata, // Read data
    output logic [1:0]               s_axi_rresp, // Read response
    output logic                     s_axi_rvalid, // Read valid
    input  wire logic                s_axi_rready, // Read ready
    // Encoders and inputs
    input  wire logic [POS_W-1:0]    pos_a, // Axis A load encoder
    input  wire logic [POS_W-1:0]    pos_b, // Axis B encoder
    input  wire logic [POS_W-1:0]    aux_pos, // Motor encoder
    input  wire logic                axis_a_latch_input, // Input one
    input  wire logic                axis_b_latch_input, // Input two
    input  wire ahl_pkg::ahl_sense_s sense, // Home, index, stopped
    // To the servo filter and profiler
    output logic [POS_W-1:0]         pi_feedback, // P and I feedback
    output logic [POS_W-1:0]         d_feedback, // D feedback
    output logic [15:0]              smoothing_factor, // Current factor
    output ahl_pkg::ahl_move_s       home_move // Homing request
);
    // --------------------
    // Registers
    // --------------------
    logic [31:0]      ctrl_r;       // Control bits
    logic [31:0]      smooth_r;     // [15:0] independent, [31:16] vector
    logic [31:0]      speed_r;      // [15:0] slew, [31:16] creep
    logic             vec_r;        // Current move is vector type
    logic             arm_a;        // Arm pulses
    logic             arm_b;
    logic             armed_a;      // Latch states
    logic             armed_b;
    logic [POS_W-1:0] cap_a;        // Captured positions
    logic [POS_W-1:0] cap_b;
    logic             cmd_edge;     // Command strobes
    logic             cmd_index;
    logic             cmd_home;
    logic             aw_hold_r;    // Write address held
    logic [7:0]       awaddr_r;
    logic             w_hold_r;     // Write data held
    logic [31:0]      wdata_r;
    logic [3:0]       wstrb_r;
    logic             wr_go;        // Both halves present
    ahl_pkg::ahl_home_e st_r;       // Homing state
    logic             seq_home_r;   // Running full home (edge then index)
    logic             home_prev_r;  // Home level history
    logic             home_lvl;     // Home input after polarity
    logic             home_edge;    // Home transition seen
    logic             dir_r;        // Direction, 1 = forward
    logic             zero_r;       // Zero-position pulse

    // --------------------
    // Byte-lane merge, shared by ctrl_r, smooth_r and speed_r
    // --------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
        end
        return r;
    endfunction : merge

    // --------------------
    // AXI write channel: address and data taken in either order
    // --------------------
    assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
    assign s_axi_bresp   = 2'h0;
    assign wr_go         = aw_hold_r & w_hold_r;

    // Capture address and data, release once both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
            end
        end
    end

    // Write response, one cycle after both halves held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register writes; unmapped addresses are accepted and ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r   <= ahl_pkg::CTRL_RST;
            smooth_r <= ahl_pkg::SMOOTH_RST;
            speed_r  <= ahl_pkg::SPEED_RST;
        end else if (wr_go) begin
            case (awaddr_r)
                ahl_pkg::ADDR_CTRL:   ctrl_r   <= merge(ctrl_r, wdata_r, wstrb_r);   // [R2] [R7]
                ahl_pkg::ADDR_SMOOTH: smooth_r <= merge(smooth_r, wdata_r, wstrb_r); // [R3]
                ahl_pkg::ADDR_SPEED:  speed_r  <= merge(speed_r, wdata_r, wstrb_r);
                default: ;
            endcase
        end
    end

    // Command strobes: one-cycle pulses from a write to the command word
    always_comb begin
        logic cw;
        cw     = wr_go && (awaddr_r == ahl_pkg::ADDR_CMD) && wstrb_r[0];
        arm_a  = cw && wdata_r[ahl_pkg::CMD_ARM_A_BIT];
        arm_b  = cw && wdata_r[ahl_pkg::CMD_ARM_B_BIT];
        cmd_edge  = cw && wdata_r[ahl_pkg::CMD_EDGE_BIT];
        cmd_index = cw && wdata_r[ahl_pkg::CMD_INDEX_BIT];
        cmd_home  = cw && wdata_r[ahl_pkg::CMD_HOME_BIT];
    end

    // Move type held from the last command write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vec_r <= 1'b0;
        end else if (wr_go && (awaddr_r == ahl_pkg::ADDR_CMD) && wstrb_r[0]) begin
            vec_r <= wdata_r[ahl_pkg::CMD_VEC_BIT];
        end
    end

    // --------------------
    // AXI read channel: one read at a time, data registered
    // --------------------
    assign s_axi_arready = ~s_axi_rvalid;
    assign s_axi_rresp   = 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                ahl_pkg::ADDR_CTRL:    s_axi_rdata <= ctrl_r;
                ahl_pkg::ADDR_SMOOTH:  s_axi_rdata <= smooth_r;
                ahl_pkg::ADDR_SPEED:   s_axi_rdata <= speed_r;
                ahl_pkg::ADDR_STATUS:  s_axi_rdata <= {27'h0, st_r, armed_b, armed_a}; // [R16]
                ahl_pkg::ADDR_LATCH_A: s_axi_rdata <= 32'(cap_a);   // [R18]
                ahl_pkg::ADDR_LATCH_B: s_axi_rdata <= 32'(cap_b);   // [R18]
                default:               s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // --------------------
    // Dual loop feedback split
    // --------------------
    // Stepper mode disables the secondary encoder, so D falls back to main
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pi_feedback <= '0;
            d_feedback  <= '0;
        end else begin
            pi_feedback <= pos_a; // [R1]
            if (ctrl_r[ahl_pkg::CTRL_DUAL_BIT] && !ctrl_r[ahl_pkg::CTRL_STEPPER_BIT]) begin
                d_feedback <= aux_pos; // [R1] [R2] [R19]
            end else begin
                d_feedback <= pos_a;
            end
        end
    end

    // Smoothing factor for the active move type, 0xFFFF stands for 1.0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            smoothing_factor <= 16'hFFFF;
        end else begin
            smoothing_factor <= vec_r ? smooth_r[31:16] : smooth_r[15:0];   // [R3] [R4]
        end
    end

    // --------------------
    // Homing sequencer
    // --------------------
    assign home_lvl  = sense.home_in ^ ctrl_r[ahl_pkg::CTRL_HPOL_BIT]; // [R7]
    assign home_edge = home_lvl ^ home_prev_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            home_prev_r <= 1'b0;
        end else begin
            home_prev_r <= home_lvl;
        end
    end

    // Sequence state; a new command while busy is ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r       <= ahl_pkg::HS_IDLE;
            seq_home_r <= 1'b0;
            dir_r      <= 1'b1;
            zero_r     <= 1'b0;
        end else begin
            zero_r <= 1'b0;
            case (st_r)
                ahl_pkg::HS_IDLE: begin
                    if (cmd_edge || cmd_home) begin
                        st_r       <= ahl_pkg::HS_SLEW; // [R5] [R12]
                        seq_home_r <= cmd_home;
                        dir_r      <= ~home_lvl; // [R6]
                    end else if (cmd_index) begin
                        st_r  <= ahl_pkg::HS_INDEX; // [R12]
                        dir_r <= 1'b1;
                    end
                end
                ahl_pkg::HS_SLEW: begin
                    if (home_edge) st_r <= ahl_pkg::HS_DECEL; // [R5] [R8]
                end
                ahl_pkg::HS_DECEL: begin
                    if (sense.stopped) begin
                        if (seq_home_r) begin
                            st_r  <= ahl_pkg::HS_CREEP; // [R9]
                            dir_r <= ~dir_r;
                        end else begin
                            st_r <= ahl_pkg::HS_IDLE; // [R5]
                        end
                    end
                end
                ahl_pkg::HS_CREEP: begin
                    if (home_edge) begin
                        st_r  <= ahl_pkg::HS_INDEX; // [R10]
                        dir_r <= 1'b1;
                    end
                end
                ahl_pkg::HS_INDEX: begin
                    if (sense.index_in) begin
                        st_r   <= ahl_pkg::HS_IDLE;
                        zero_r <= 1'b1; // [R11]
                    end
                end
                default: st_r <= ahl_pkg::HS_IDLE;
            endcase
        end
    end

    // Motion request toward the profiler
    always_comb begin
        home_move.active   = (st_r != ahl_pkg::HS_IDLE);
        home_move.dir_fwd  = dir_r;
        home_move.decel    = (st_r == ahl_pkg::HS_DECEL); // [R8]
        home_move.zero_pos = zero_r; // [R11]
        case (st_r)
            ahl_pkg::HS_SLEW:  home_move.speed = speed_r[15:0];
            ahl_pkg::HS_CREEP: home_move.speed = speed_r[31:16]; // [R9]
            ahl_pkg::HS_INDEX: home_move.speed = speed_r[31:16];
            default:           home_move.speed = 16'h0000;
        endcase
    end

    // --------------------
    // Position latches, general inputs one and two
    // --------------------
    ahl_latch #(.POS_W(POS_W)) u_latch_a (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .arm      (arm_a),
        .rising   (ctrl_r[ahl_pkg::CTRL_EDGE_A_BIT]),
        .lat_in   (axis_a_latch_input), // [R15]
        .pos      (pos_a),
        .armed    (armed_a),
        .captured (cap_a)
    );

    ahl_latch #(.POS_W(POS_W)) u_latch_b (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .arm      (arm_b),
        .rising   (ctrl_r[ahl_pkg::CTRL_EDGE_B_BIT]),
        .lat_in   (axis_b_latch_input), // [R15]
        .pos      (pos_b),
        .armed    (armed_b),
        .captured (cap_b)
    );

    // Width limit on the register readout
    if (POS_W < 1 || POS_W > 32) begin : g_bad_width
        $error("POS_W must be 1..32");
    end
endmodule : ahl_axis_ctrl

/* tb/ahl_props.sv */
module ahl_props #(
    parameter int POS_W = 32                         // Position width
) (
    input wire logic                aclk,            // Clock
    input wire logic                aresetn,         // Reset, active low
    input wire logic                s_axi_arready,   // Read address ready
    input wire logic [31:0]         s_axi_rdata,     // Read data
    input wire logic                s_axi_rvalid,    // Read valid
    input wire logic                s_axi_rready,    // Read ready
    input wire logic [1:0]          s_axi_bresp,     // Write response
    input wire logic                s_axi_bvalid,    // Write response valid
    input wire logic                s_axi_bready,    // Write response ready
    input wire logic [POS_W-1:0]    pos_a,           // Load encoder
    input wire logic [POS_W-1:0]    pi_feedback,     // P and I feedback
    input wire ahl_pkg::ahl_sense_s sense,           // Home, index, stopped
    input wire ahl_pkg::ahl_move_s  home_move        // Homing request
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Switch level changed one cycle before the stop request
    sequence s_switch_moved;
        $past(sense.home_in) != $past(sense.home_in, 2);
    endsequence
    // Ramp-down finished while stopping
    sequence s_ramp_done;
        home_move.decel && sense.stopped;
    endsequence
    AST_PI_LOAD: assert property ($past(aresetn) |-> pi_feedback == $past(pos_a))
        else $error("PI feedback not load");
    AST_DECEL_EDGE: assert property ($rose(home_move.decel) |-> s_switch_moved)
        else $error("Stop without switch change");
    AST_DECEL_STOP: assert property (s_ramp_done |=> !home_move.decel)
        else $error("Stop request held");
    AST_ZERO_PULSE: assert property (home_move.zero_pos |=> !home_move.zero_pos)
        else $error("Zero pulse too long");
    AST_ZERO_IDX: assert property (home_move.zero_pos |-> $past(sense.index_in))
        else $error("Zero without index");
    AST_ZERO_DONE: assert property (home_move.zero_pos |-> !home_move.active)
        else $error("Active after zero");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("rdata changed");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_bresp == 2'b00)
        else $error("Read taken while pending");
endmodule : ahl_props

bind ahl_axis_ctrl ahl_props #(.POS_W(POS_W)) ahl_props_inst (
    .aclk, .aresetn, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .pos_a, .pi_feedback, .sense, .home_move
);

/* tb/ahl_plant.sv */
module ahl_plant (
    input wire logic                aclk,   // Clock
    input wire logic                inv,    // Switch wired inverted
    input wire ahl_pkg::ahl_move_s  mv,     // Motion request
    output ahl_pkg::ahl_sense_s     sense,  // Switch, index, stopped
    output logic [31:0]             pos     // Axis position
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] pos_r = 32'h0; // Position, no reset in a real axis
    logic [2:0]  ramp_r = 3'h4;             // Ramp-down cycles left
    logic        hold;
    assign hold = mv.decel && ramp_r == 3'h0;
    // Axis keeps coasting a few cycles after a stop request, as a real load does
    always_ff @(posedge aclk) begin
        ramp_r <= mv.decel ? ramp_r - 3'(ramp_r != 3'h0) : 3'h4;
        if (mv.zero_pos) begin
            pos_r <= 32'h0;
        end else if (mv.active && !hold) begin
            pos_r <= mv.dir_fwd ? pos_r + 32'h1 : pos_r - 32'h1;
        end
    end
    assign pos            = pos_r;
    assign sense.home_in  = ($signed(pos_r) >= 40) ^ inv;
    assign sense.index_in = pos_r[5:0] == 6'h00;
    assign sense.stopped  = !mv.active || hold;
endmodule : ahl_plant

/* tb/ahl_axis_ctrl_tb.sv */
module ahl_axis_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, inv = 1'b0, e;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, axis_a_latch_input = 1'b0;
    logic axis_b_latch_input = 1'b1, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, pos_b = 32'h0, aux_pos = 32'hA5A5_0001;
    logic [31:0] s_axi_rdata, pos_a, pi_feedback, d_feedback, v;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] smoothing_factor;
    int          error_cnt = 0, num_checks = 0, cyc = 0;
    ahl_pkg::ahl_sense_s sense;
    ahl_pkg::ahl_move_s  home_move;
    always #4 aclk = ~aclk;
    ahl_axis_ctrl ahl_axis_ctrl_inst (.*);
    ahl_plant ahl_plant_inst (.aclk, .inv, .mv(home_move), .sense, .pos(pos_a));
    // --------
    // Bus tasks
    // --------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!tb);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic ta, tr;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!tr);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] g;
        rd(a, g);
        chk($sformatf("register %h", a), x, g);
    endtask : rc
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(ahl_pkg::ADDR_CTRL, ahl_pkg::CTRL_RST);
        rc(ahl_pkg::ADDR_SMOOTH, ahl_pkg::SMOOTH_RST);
        rc(ahl_pkg::ADDR_SPEED, ahl_pkg::SPEED_RST);
        rc(8'h1C, 32'h0);
        axis_a_latch_input <= 1'b1;
        repeat (3) @(posedge aclk);
        rc(ahl_pkg::ADDR_LATCH_A, 32'h0);
        chk("factor", 32'hFFFF, 32'(smoothing_factor));
        wr(ahl_pkg::ADDR_SMOOTH, 32'h4000_8000);
        wr(ahl_pkg::ADDR_CMD, 32'h20);
        chk("factor", 32'h4000, 32'(smoothing_factor));
        wr(ahl_pkg::ADDR_CMD, 32'h02);
        chk("factor", 32'h8000, 32'(smoothing_factor));
        wr(ahl_pkg::ADDR_CTRL, 32'h1);
        chk("d feedback", aux_pos, d_feedback);
        wr(ahl_pkg::ADDR_CTRL, 32'h11);
        chk("d feedback", pos_a, d_feedback);
        wr(ahl_pkg::ADDR_CTRL, 32'h0);
        chk("d feedback", pos_a, d_feedback);
        $display("test registers done");
        // Find edge with inverted switch reading
        wr(ahl_pkg::ADDR_CTRL, 32'h2);
        inv <= 1'b1;
        @(posedge aclk);
        e = !(sense.home_in ^ 1'b1);
        wr(ahl_pkg::ADDR_CMD, 32'h4);
        chk("direction", 32'(e), 32'(home_move.dir_fwd));
        chk("speed", 32'(ahl_pkg::SPEED_RST[15:0]), 32'(home_move.speed));
        do @(negedge aclk); while (home_move.active);
        @(posedge aclk);
        rd(ahl_pkg::ADDR_STATUS, v);
        chk("state", 32'h0, 32'(v[4:2]));
        // Latch: wrong edge ignored, one capture per arming
        wr(ahl_pkg::ADDR_CTRL, 32'h4);
        pos_b <= 32'h1234_5678;
        wr(ahl_pkg::ADDR_CMD, 32'h3);
        axis_a_latch_input <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(ahl_pkg::ADDR_STATUS, v);
        chk("armed", 32'h3, 32'(v[1:0]));
        axis_a_latch_input <= 1'b1;
        axis_b_latch_input <= 1'b0;
        repeat (2) @(posedge aclk);
        pos_b <= 32'h0BAD_0001;
        rd(ahl_pkg::ADDR_STATUS, v);
        chk("armed", 32'h0, 32'(v[1:0]));
        rc(ahl_pkg::ADDR_LATCH_A, pos_a);
        axis_b_latch_input <= 1'b1;
        @(posedge aclk);
        axis_b_latch_input <= 1'b0;
        repeat (3) @(posedge aclk);
        rc(ahl_pkg::ADDR_LATCH_B, 32'h1234_5678);
        $display("test latch done");
        wr(ahl_pkg::ADDR_CMD, 32'h8);
        do @(negedge aclk); while (!home_move.zero_pos);
        @(posedge aclk);
        inv <= 1'b0;
        wr(ahl_pkg::ADDR_CTRL, 32'h0);
        e = !sense.home_in;
        wr(ahl_pkg::ADDR_CMD, 32'h10);
        chk("direction", 32'(e), 32'(home_move.dir_fwd));
        do @(negedge aclk); while (!home_move.decel);
        do @(negedge aclk); while (home_move.decel);
        chk("direction", 32'(!e), 32'(home_move.dir_fwd));
        chk("speed", 32'(ahl_pkg::SPEED_RST[31:16]), 32'(home_move.speed));
        do @(negedge aclk); while (!(home_move.active && sense.index_in));
        chk("direction", 32'h1, 32'(home_move.dir_fwd));
        do @(negedge aclk); while (!home_move.zero_pos);
        repeat (2) @(negedge aclk);
        chk("position", 32'h0, pi_feedback);
        $display("test homing done");
        stop_test();
    end
endmodule : ahl_axis_ctrl_tb
